// ### duc_update_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Output use: pin released when control bit is one, driven low when zero.
// - Input use: reading the control bit returns the pin level.
// - Any reset sets the control bit to one, pin released.
// - Running correction engine sets busy flag and pulls busy pin low.
// - Busy pin released once data registers are updated.
// - Clear low forces outputs cleared and ignores load strobes.
// - Sync mode: clear released with strobe high keeps outputs cleared until strobe falls.
// - Strobe held low: releasing clear restores outputs from latches at once.
// - Clear alters no register and no latch.
// - Power-on loads strap-chosen data, offset, and default gain, zero, input.
// - Reset data code: binary 000h/800h, two's complement 800h/000h by strap.
// - Gain-six offset reset: 99Ah binary, 19Ah two's complement.
// - Single supply: offset off, same strap data codes.
// - Reset low holds data, latches, outputs at reset values; defaults loaded.
// - During reset, bus inputs ignored and data lines released.
// - After reset, outputs keep reset values until new data written.
// - Load strobe level at power-on fixes asynchronous or synchronous mode.
// - Load updates only latches of channels accessed since last load.
// - Async mode ignores loads; engine off updates on chip select rise.
// - Async mode with engine: latch follows each engine data write.
// - Sync mode: strobe fall or software load updates all accessed latches together.
// - Load during busy is deferred until busy clears.
// - Sync mode: no request leaves latches and outputs unchanged.
module duc_update_ctrl
	import duc_pkg::*;
(
	// Clock and power-on reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// Asynchronous pins
	input wire logic HW_RESET_N,
	input wire logic ASYNC_CLEAR_N,
	input wire logic LOAD_STROBE_N,
	// Straps
	input wire logic RESET_VALUE_SELECT,
	input wire logic DATA_FORMAT_SELECT,
	input wire logic SINGLE_SUPPLY,
	// Host write, already decoded on chip select rise
	input duc_pkg::duc_write_s HOST_WRITE,
	input wire logic SOFTWARE_LOAD,
	input wire logic CORRECTION_ENABLE,
	// Correction engine writes
	input duc_pkg::duc_write_s ENGINE_WRITE,
	input wire logic ENGINE_RUNNING,
	// General-purpose pin
	input wire logic GPIO_WRITE,
	input wire logic GPIO_WDATA,
	input wire logic GPIO_IN,
	output logic GPIO_OUT,
	output logic GPIO_OE,
	output logic GPIO_READ,
	// Busy open-drain pin
	output logic BUSY_OUT,
	output logic BUSY_OE,
	output logic GLOBAL_BUSY_FLAG,
	// Bus lines and status
	output logic DATA_BUS_OE,
	output logic COMM_ENABLE,
	output logic UPDATE_MODE,
	// Converter state
	output logic [CHANNELS*DATA_W-1:0] DAC_DATA,
	output logic [CHANNELS*DATA_W-1:0] DAC_LATCH,
	output logic [CHANNELS*DATA_W-1:0] DAC_OUTPUT,
	output logic [CHANNELS-1:0] OUTPUT_CLEARED,
	output logic [DATA_W-1:0] OFFSET_CODE,
	output logic [DATA_W-1:0] GAIN_CODE,
	output logic [DATA_W-1:0] ZERO_CODE,
	output logic [DATA_W-1:0] INPUT_DATA
);
	import duc_pkg::*;

	logic hw_reset_n;
	logic clear_n;
	logic strobe_n;
	logic strobe_prev;
	logic mode_captured;
	logic gpio_bit;
	logic load_pending;
	logic clear_hold;
	logic [CHANNELS-1:0] accessed;
	logic [DATA_W-1:0] data_reg [CHANNELS];
	logic [DATA_W-1:0] latch_reg [CHANNELS];
	duc_mode_e mode;
	duc_state_e state;
	duc_state_e next_state;
	duc_reset_s rst_codes;
	logic strobe_fall;
	logic load_request;
	logic load_all;
	logic in_reset;
	logic host_ok;

	function automatic logic [CHANNELS-1:0] ch_onehot(input duc_write_s w);
		ch_onehot = w.write ? (CHANNELS'(1) << w.channel) : '0;
	endfunction

	duc_sync u_sync_rst (.clk(CLOCK), .d(HW_RESET_N), .init(1'b1), .q(hw_reset_n));
	duc_sync u_sync_clr (.clk(CLOCK), .d(ASYNC_CLEAR_N), .init(1'b1), .q(clear_n));
	duc_sync u_sync_ld (.clk(CLOCK), .d(LOAD_STROBE_N), .init(1'b1), .q(strobe_n));

	duc_reset_codes u_codes (
		.reset_value_select(RESET_VALUE_SELECT),
		.data_format_select(DATA_FORMAT_SELECT),
		.single_supply(SINGLE_SUPPLY),
		.codes(rst_codes)
	);

	assign in_reset = !RST_N || !hw_reset_n;
	assign host_ok = !in_reset;
	assign strobe_fall = strobe_prev && !strobe_n;

	always_ff @(posedge CLOCK) begin
		strobe_prev <= strobe_n;
	end

	// mode fixed at power-on; synchroniser needs a few cycles, so capture late
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			mode_captured <= 1'b0;
			mode <= DUC_ASYNC;
		end else if (!mode_captured) begin
			mode_captured <= 1'b1;
			mode <= strobe_n ? DUC_SYNC : DUC_ASYNC;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (in_reset) begin
			gpio_bit <= GPIO_RESET;
		end else if (GPIO_WRITE) begin
			gpio_bit <= GPIO_WDATA;
		end
	end

	assign GPIO_OUT = 1'b0;
	assign GPIO_OE = !gpio_bit;
	assign GPIO_READ = GPIO_IN;

	always_ff @(posedge CLOCK) begin
		if (in_reset) begin
			GLOBAL_BUSY_FLAG <= 1'b0;
		end else begin
			GLOBAL_BUSY_FLAG <= CORRECTION_ENABLE && ENGINE_RUNNING;
		end
	end
	assign BUSY_OUT = 1'b0;
	assign BUSY_OE = GLOBAL_BUSY_FLAG;

	assign DATA_BUS_OE = 1'b0;
	assign COMM_ENABLE = host_ok;
	assign UPDATE_MODE = (mode == DUC_SYNC);

	// strobes ignored while clear low; nothing without a request
	assign load_request = (mode == DUC_SYNC) && clear_n && host_ok
		&& (strobe_fall || SOFTWARE_LOAD);

	// Deferred load state
	always_comb begin
		next_state = state;
		load_all = 1'b0;
		case (state)
			DUC_IDLE: begin
				if (load_request) begin
					if (CORRECTION_ENABLE && GLOBAL_BUSY_FLAG) begin
						next_state = DUC_WAIT_BUSY;
					end else begin
						load_all = 1'b1;
					end
				end
			end
			DUC_WAIT_BUSY: begin
				if (!GLOBAL_BUSY_FLAG) begin
					load_all = 1'b1;
					next_state = DUC_IDLE;
				end
			end
			default: next_state = DUC_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (in_reset) begin
			state <= DUC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign load_pending = (state == DUC_WAIT_BUSY);

	// track accessed channels; a write in the load cycle survives
	always_ff @(posedge CLOCK) begin
		if (in_reset) begin
			accessed <= '0;
		end else if (mode == DUC_SYNC) begin
			accessed <= (load_all ? '0 : accessed)
				| (host_ok ? (ch_onehot(HOST_WRITE) | ch_onehot(ENGINE_WRITE)) : '0);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (in_reset) begin
			clear_hold <= 1'b0;
		end else if (!clear_n) begin
			clear_hold <= 1'b1;
		end else if (!strobe_n || mode == DUC_ASYNC) begin
			clear_hold <= 1'b0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			logic host_hit;
			logic eng_hit;
			assign host_hit = host_ok && HOST_WRITE.write && (HOST_WRITE.channel == CH_W'(g));
			assign eng_hit = host_ok && ENGINE_WRITE.write && (ENGINE_WRITE.channel == CH_W'(g));
			always_ff @(posedge CLOCK) begin
				if (in_reset) begin
					data_reg[g] <= rst_codes.dac_code;
				end else if (CORRECTION_ENABLE && eng_hit) begin
					data_reg[g] <= ENGINE_WRITE.data;
				end else if (!CORRECTION_ENABLE && host_hit) begin
					data_reg[g] <= HOST_WRITE.data;
				end
			end
			always_ff @(posedge CLOCK) begin
				if (in_reset) begin
					latch_reg[g] <= rst_codes.dac_code;
				end else if (mode == DUC_ASYNC) begin
					if (CORRECTION_ENABLE && eng_hit) begin
						latch_reg[g] <= ENGINE_WRITE.data;
					end else if (!CORRECTION_ENABLE && host_hit) begin
						latch_reg[g] <= HOST_WRITE.data;
					end
				end else if (load_all && accessed[g]) begin
					latch_reg[g] <= data_reg[g];
				end
			end
			assign DAC_DATA[g*DATA_W +: DATA_W] = data_reg[g];
			assign DAC_LATCH[g*DATA_W +: DATA_W] = latch_reg[g];
			always_ff @(posedge CLOCK) begin
				if (in_reset) begin
					DAC_OUTPUT[g*DATA_W +: DATA_W] <= rst_codes.dac_code;
					OUTPUT_CLEARED[g] <= 1'b0;
				end else begin
					DAC_OUTPUT[g*DATA_W +: DATA_W] <= latch_reg[g];
					OUTPUT_CLEARED[g] <= !clear_n || clear_hold;
				end
			end
		end
	endgenerate

	always_ff @(posedge CLOCK) begin
		if (in_reset) begin
			OFFSET_CODE <= rst_codes.offset_code;
			GAIN_CODE <= GAIN_DEFAULT;
			ZERO_CODE <= ZERO_DEFAULT;
			INPUT_DATA <= CODE_ZERO;
		end else if (host_ok && HOST_WRITE.write && CORRECTION_ENABLE) begin
			INPUT_DATA <= HOST_WRITE.data;
		end
	end

	logic unused;
	assign unused = load_pending;
endmodule

// ### duc_pkg.sv
package duc_pkg;
	localparam int CHANNELS = 8;
	localparam int DATA_W = 12;
	localparam int CH_W = 3;
	localparam logic [11:0] CODE_ZERO = 12'h000;
	localparam logic [11:0] CODE_MID = 12'h800;
	localparam logic [11:0] OFFSET_USB = 12'h99a;
	localparam logic [11:0] OFFSET_BTC = 12'h19a;
	localparam logic [11:0] OFFSET_OFF = 12'h000;
	localparam logic [11:0] GAIN_DEFAULT = 12'hfff;
	localparam logic [11:0] ZERO_DEFAULT = 12'h000;
	localparam logic GPIO_RESET = 1'b1;
	typedef enum logic {DUC_ASYNC, DUC_SYNC} duc_mode_e;
	typedef enum logic [1:0] {DUC_IDLE, DUC_WAIT_BUSY, DUC_CLEARED} duc_state_e;
	typedef struct packed {
		logic write;
		logic [CH_W-1:0] channel;
		logic [DATA_W-1:0] data;
	} duc_write_s;
	typedef struct packed {
		logic [DATA_W-1:0] offset_code;
		logic [DATA_W-1:0] dac_code;
	} duc_reset_s;
endpackage

// ### duc_sync.sv
`timescale 1ns/1ps
module duc_sync (
	input wire logic clk,
	input wire logic d,
	input wire logic init,
	output logic q
);
	logic s1;
	logic s2;
	logic s3;
	// Change counts once stages two and three agree
	always_ff @(posedge clk) begin
		s1 <= d;
		s2 <= s1;
		s3 <= s2;
		if (s2 == s3) begin
			q <= s3;
		end
	end
	logic unused_init;
	assign unused_init = init;
endmodule

// ### duc_reset_codes.sv
`timescale 1ns/1ps
module duc_reset_codes
	import duc_pkg::*;
(
	input wire logic reset_value_select,
	input wire logic data_format_select,
	input wire logic single_supply,
	output duc_pkg::duc_reset_s codes
);
	always_comb begin
		codes.dac_code = (reset_value_select ^ data_format_select) ? CODE_MID : CODE_ZERO;
		codes.offset_code = data_format_select ? OFFSET_BTC : OFFSET_USB;
		if (single_supply) begin
			codes.offset_code = OFFSET_OFF;
		end
	end
endmodule

// ### duc_update_ctrl_monitor.sv
`timescale 1ns/1ps
module duc_update_ctrl_monitor
	import duc_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// Inputs
	input wire logic ASYNC_CLEAR_N,
	input wire logic RESET_VALUE_SELECT,
	input wire logic DATA_FORMAT_SELECT,
	input duc_pkg::duc_write_s HOST_WRITE,
	input duc_pkg::duc_write_s ENGINE_WRITE,
	input wire logic CORRECTION_ENABLE,
	input wire logic ENGINE_RUNNING,
	input wire logic GPIO_WRITE,
	input wire logic GPIO_WDATA,
	input wire logic GPIO_IN,
	// Outputs
	input wire logic GPIO_OUT,
	input wire logic GPIO_OE,
	input wire logic GPIO_READ,
	input wire logic BUSY_OUT,
	input wire logic BUSY_OE,
	input wire logic GLOBAL_BUSY_FLAG,
	input wire logic DATA_BUS_OE,
	input wire logic COMM_ENABLE,
	input wire logic UPDATE_MODE,
	input wire logic [CHANNELS*DATA_W-1:0] DAC_DATA,
	input wire logic [CHANNELS*DATA_W-1:0] DAC_LATCH,
	input wire logic [CHANNELS-1:0] OUTPUT_CLEARED
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	property p_gpio_drive;
		GPIO_WRITE && COMM_ENABLE |=> GPIO_OE == !$past(GPIO_WDATA) && !GPIO_OUT;
	endproperty
	a_gpio_drive: assert property (p_gpio_drive) else $error("gpio drive wrong");
	property p_gpio_read;
		GPIO_READ == GPIO_IN;
	endproperty
	a_gpio_read: assert property (p_gpio_read) else $error("gpio read wrong");
	property p_busy_set;
		CORRECTION_ENABLE && ENGINE_RUNNING && COMM_ENABLE |=> GLOBAL_BUSY_FLAG && BUSY_OE && !BUSY_OUT;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not set");
	property p_busy_free;
		!ENGINE_RUNNING |=> !BUSY_OE;
	endproperty
	a_busy_free: assert property (p_busy_free) else $error("busy not released");
	property p_clear;
		(!ASYNC_CLEAR_N && COMM_ENABLE) [*6] |-> OUTPUT_CLEARED == 8'hff;
	endproperty
	a_clear: assert property (p_clear) else $error("outputs not cleared");
	property p_clear_keeps;
		OUTPUT_CLEARED != 0 && COMM_ENABLE && !HOST_WRITE.write && !ENGINE_WRITE.write
			|=> $stable(DAC_DATA);
	endproperty
	a_clear_keeps: assert property (p_clear_keeps) else $error("clear altered data");
	property p_hw_reset;
		!COMM_ENABLE [*2] |-> DAC_DATA == {CHANNELS{(RESET_VALUE_SELECT ^ DATA_FORMAT_SELECT)
			? 12'h800 : 12'h000}};
	endproperty
	a_hw_reset: assert property (p_hw_reset) else $error("reset code wrong");
	property p_bus_off;
		!COMM_ENABLE |-> !DATA_BUS_OE;
	endproperty
	a_bus_off: assert property (p_bus_off) else $error("data bus driven");
	property p_async_upd;
		!UPDATE_MODE && COMM_ENABLE && HOST_WRITE.write && !CORRECTION_ENABLE
			|=> DAC_LATCH[$past(HOST_WRITE.channel)*DATA_W +: DATA_W] == $past(HOST_WRITE.data);
	endproperty
	a_async_upd: assert property (p_async_upd) else $error("async latch stale");
	c_busy: cover property (GLOBAL_BUSY_FLAG);
	c_clear: cover property (OUTPUT_CLEARED == 8'hff);
	c_reset: cover property (!COMM_ENABLE);
endmodule
bind duc_update_ctrl duc_update_ctrl_monitor u_duc_update_ctrl_monitor (.*);

// ### duc_host_model.sv
`timescale 1ns/1ps
module duc_host_model
	import duc_pkg::*;
(
	// Clock and reset pin
	input wire logic clk,
	input wire logic hw_reset_n,
	// Host requests
	output duc_pkg::duc_write_s host_write,
	output logic software_load
);
	initial begin
		host_write = '0;
		software_load = 1'b0;
	end
	task automatic write(input logic [2:0] ch, input logic [11:0] d);
		if (hw_reset_n) begin
			@(posedge clk) host_write <= '{1'b1, ch, d};
			// Released bus shows junk
			@(posedge clk) host_write <= '{1'b0, ch, ~d};
		end
	endtask
	task automatic load();
		repeat (3) @(posedge clk);
		software_load <= 1'b1;
		@(posedge clk) software_load <= 1'b0;
	endtask
endmodule

// ### tb_duc_update_ctrl.sv
`timescale 1ns/1ps
module tb_duc_update_ctrl;
	import duc_pkg::*;
	logic CLOCK = 0, RST_N = 0, HW_RESET_N = 1, ASYNC_CLEAR_N = 1, LOAD_STROBE_N = 1;
	logic CORRECTION_ENABLE = 0, ENGINE_RUNNING = 0, GPIO_WRITE = 0, GPIO_WDATA = 1, pin_ext = 1;
	duc_write_s HOST_WRITE, ENGINE_WRITE = '0;
	logic SOFTWARE_LOAD, GPIO_OUT, GPIO_OE, GPIO_READ, BUSY_OUT, BUSY_OE, GLOBAL_BUSY_FLAG;
	logic DATA_BUS_OE, COMM_ENABLE, UPDATE_MODE;
	logic [95:0] DAC_DATA, DAC_LATCH, DAC_OUTPUT, e;
	logic [7:0] OUTPUT_CLEARED;
	logic [11:0] OFFSET_CODE, GAIN_CODE, ZERO_CODE, INPUT_DATA;
	int fails = 0, total_checks = 0;
	wire GPIO_IN = GPIO_OE ? GPIO_OUT : pin_ext;
	initial forever #5 CLOCK = ~CLOCK;
	duc_update_ctrl u_duc_update_ctrl (.CLOCK(CLOCK), .RST_N(RST_N), .HW_RESET_N(HW_RESET_N),
		.ASYNC_CLEAR_N(ASYNC_CLEAR_N), .LOAD_STROBE_N(LOAD_STROBE_N),
		.RESET_VALUE_SELECT(1'b1), .DATA_FORMAT_SELECT(1'b0), .SINGLE_SUPPLY(1'b0),
		.HOST_WRITE(HOST_WRITE), .SOFTWARE_LOAD(SOFTWARE_LOAD),
		.CORRECTION_ENABLE(CORRECTION_ENABLE), .ENGINE_WRITE(ENGINE_WRITE),
		.ENGINE_RUNNING(ENGINE_RUNNING), .GPIO_WRITE(GPIO_WRITE), .GPIO_WDATA(GPIO_WDATA),
		.GPIO_IN(GPIO_IN), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE), .GPIO_READ(GPIO_READ),
		.BUSY_OUT(BUSY_OUT), .BUSY_OE(BUSY_OE), .GLOBAL_BUSY_FLAG(GLOBAL_BUSY_FLAG),
		.DATA_BUS_OE(DATA_BUS_OE), .COMM_ENABLE(COMM_ENABLE), .UPDATE_MODE(UPDATE_MODE),
		.DAC_DATA(DAC_DATA), .DAC_LATCH(DAC_LATCH), .DAC_OUTPUT(DAC_OUTPUT),
		.OUTPUT_CLEARED(OUTPUT_CLEARED), .OFFSET_CODE(OFFSET_CODE), .GAIN_CODE(GAIN_CODE),
		.ZERO_CODE(ZERO_CODE), .INPUT_DATA(INPUT_DATA));
	duc_host_model u_duc_host_model (.clk(CLOCK), .hw_reset_n(HW_RESET_N),
		.host_write(HOST_WRITE), .software_load(SOFTWARE_LOAD));
	task automatic tick(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask
	task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Bounded wait on the busy flag
	task automatic wait_busy(input logic v);
		int i;
		#1;
		for (i = 0; i < 20 && GLOBAL_BUSY_FLAG !== v; i++)
			tick(1);
		chk("busy flag", v, GLOBAL_BUSY_FLAG);
		if (GLOBAL_BUSY_FLAG !== v)
			tally_and_finish();
	endtask
	task automatic t_reset();
		e = {8{12'h800}};
		chk("data", e, DAC_DATA);
		chk("latch", e, DAC_LATCH);
		chk("offset", 12'h99a, OFFSET_CODE);
		chk("input", 12'h000, INPUT_DATA);
		chk("gain", GAIN_DEFAULT, GAIN_CODE);
		chk("zero", ZERO_DEFAULT, ZERO_CODE);
		chk("mode", 1'b1, UPDATE_MODE);
		chk("gpio oe", 1'b0, GPIO_OE);
		$display("reset test done");
	endtask
	task automatic t_sync();
		u_duc_host_model.write(3'h2, 12'h123);
		u_duc_host_model.write(3'h5, 12'h456);
		tick(10);
		chk("latch idle", e, DAC_LATCH);
		u_duc_host_model.load();
		tick(2);
		e[24 +: 12] = 12'h123;
		e[60 +: 12] = 12'h456;
		chk("latch load", e, DAC_LATCH);
		$display("sync test done");
	endtask
	task automatic t_clear();
		@(posedge CLOCK) ASYNC_CLEAR_N <= 1'b0;
		tick(7);
		chk("cleared", 8'hff, OUTPUT_CLEARED);
		@(posedge CLOCK) ASYNC_CLEAR_N <= 1'b1;
		tick(8);
		chk("still cleared", 8'hff, OUTPUT_CLEARED);
		chk("data kept", e, DAC_DATA);
		@(posedge CLOCK) LOAD_STROBE_N <= 1'b0;
		tick(8);
		chk("uncleared", 8'h00, OUTPUT_CLEARED);
		chk("latch kept", e, DAC_LATCH);
		@(posedge CLOCK) LOAD_STROBE_N <= 1'b1;
		tick(8);
		$display("clear test done");
	endtask
	task automatic t_busy();
		@(posedge CLOCK) CORRECTION_ENABLE <= 1'b1;
		ENGINE_RUNNING <= 1'b1;
		ENGINE_WRITE <= '{1'b1, 3'h1, 12'h321};
		@(posedge CLOCK) ENGINE_WRITE <= '{1'b0, 3'h6, 12'hcde};
		wait_busy(1'b1);
		chk("busy pin", 2'b10, {BUSY_OE, BUSY_OUT});
		u_duc_host_model.load();
		tick(3);
		chk("latch deferred", e, DAC_LATCH);
		@(posedge CLOCK) ENGINE_RUNNING <= 1'b0;
		wait_busy(1'b0);
		chk("busy pin free", 1'b0, BUSY_OE);
		tick(3);
		e[12 +: 12] = 12'h321;
		chk("latch after busy", e, DAC_LATCH);
		@(posedge CLOCK) CORRECTION_ENABLE <= 1'b0;
		$display("busy test done");
	endtask
	task automatic t_gpio();
		@(posedge CLOCK) GPIO_WRITE <= 1'b1;
		GPIO_WDATA <= 1'b0;
		@(posedge CLOCK) GPIO_WRITE <= 1'b0;
		tick(2);
		chk("gpio low", 2'b10, {GPIO_OE, GPIO_IN});
		@(posedge CLOCK) pin_ext <= 1'b0;
		GPIO_WRITE <= 1'b1;
		GPIO_WDATA <= 1'b1;
		@(posedge CLOCK) GPIO_WRITE <= 1'b0;
		tick(2);
		chk("gpio read", 2'b00, {GPIO_OE, GPIO_READ});
		@(posedge CLOCK) HW_RESET_N <= 1'b0;
		GPIO_WRITE <= 1'b1;
		GPIO_WDATA <= 1'b0;
		tick(6);
		chk("comm off", 2'b00, {COMM_ENABLE, GPIO_OE});
		chk("hw data", {8{12'h800}}, DAC_DATA);
		@(posedge CLOCK) HW_RESET_N <= 1'b1;
		GPIO_WRITE <= 1'b0;
		pin_ext <= 1'b1;
		tick(8);
		chk("after hw", {8{12'h800}}, DAC_OUTPUT);
		chk("comm on", 1'b1, COMM_ENABLE);
		$display("gpio and reset test done");
	endtask
	task automatic t_async();
		@(posedge CLOCK) RST_N <= 1'b0;
		LOAD_STROBE_N <= 1'b0;
		tick(5);
		@(posedge CLOCK) RST_N <= 1'b1;
		tick(3);
		chk("async mode", 1'b0, UPDATE_MODE);
		u_duc_host_model.write(3'h3, 12'h5a5);
		tick(2);
		e = {8{12'h800}};
		e[36 +: 12] = 12'h5a5;
		chk("async latch", e, DAC_LATCH);
		@(posedge CLOCK) CORRECTION_ENABLE <= 1'b1;
		ENGINE_WRITE <= '{1'b1, 3'h4, 12'h777};
		@(posedge CLOCK) ENGINE_WRITE <= '{1'b0, 3'h4, 12'h777};
		tick(2);
		e[48 +: 12] = 12'h777;
		chk("engine latch", e, DAC_LATCH);
		@(posedge CLOCK) CORRECTION_ENABLE <= 1'b0;
		ASYNC_CLEAR_N <= 1'b0;
		tick(7);
		chk("async cleared", 8'hff, OUTPUT_CLEARED);
		@(posedge CLOCK) ASYNC_CLEAR_N <= 1'b1;
		tick(7);
		chk("strobe low restore", 8'h00, OUTPUT_CLEARED);
		$display("async test done");
	endtask
	initial begin
		tick(5);
		@(posedge CLOCK) RST_N <= 1'b1;
		tick(3);
		t_reset();
		t_sync();
		t_clear();
		t_busy();
		t_gpio();
		t_async();
		tally_and_finish();
	end
endmodule
